/* hw/adcc_pkg.sv */
//------------------------------------------------------------
// Purpose: Shared constants and types of the converter control
// Assumes: APB slave, one register per aligned word
// Notes:   Register indices times four give byte addresses
//------------------------------------------------------------
package adcc_pkg;

	//------------------------------------------------------------
	// Register indices
	//------------------------------------------------------------
	localparam logic [7:0] IDX_RESULT_LO = 8'h78;
	localparam logic [7:0] IDX_RESULT_HI = 8'h79;
	localparam logic [7:0] IDX_CTRL_A    = 8'h7A;
	localparam logic [7:0] IDX_CTRL_B    = 8'h7B;
	localparam logic [7:0] IDX_FORMAT    = 8'h7C;
	localparam logic [7:0] IDX_DIDR      = 8'h7E;

	//------------------------------------------------------------
	// Field positions
	//------------------------------------------------------------
	localparam int A_EN_BIT    = 7;
	localparam int A_START_BIT = 6;
	localparam int A_ATE_BIT   = 5;
	localparam int A_FLAG_BIT  = 4;
	localparam int A_IE_BIT    = 3;
	localparam int B_COMPARATOR_MUX_ENABLE_BIT  = 6;
	localparam int F_LALIGN_BIT = 5;

	//------------------------------------------------------------
	// Reset values and conversion lengths
	//------------------------------------------------------------
	localparam logic [7:0] RESET_BYTE   = 8'h00;
	localparam logic [9:0] RESET_RESULT = 10'h000;
	localparam logic [4:0] CONV_NORMAL  = 5'd13;
	localparam logic [4:0] CONV_FIRST   = 5'd25;
	localparam logic [2:0] TSEL_FREE    = 3'h0;

	//------------------------------------------------------------
	// Whole block state
	//------------------------------------------------------------
	typedef struct packed {
		logic       en;
		logic       start;
		logic       ate;
		logic       flag;
		logic       ie;
		logic [2:0] div;
		logic       comparator_mux_enable;
		logic [2:0] tsel;
		logic       lalign;
		logic [7:0] didr;
		logic [9:0] result;
		logic       locked;
		logic       firstPend;
		logic [6:0] preCnt;
		logic [4:0] convCnt;
		logic [4:0] convLen;
		logic       trigPrev;
		logic       flagPrev;
		logic [7:0] pin1;
		logic [7:0] pin2;
		logic [7:0] pin3;
		logic [7:0] pinStable;
		logic [7:0] pinOut;
		logic [7:0] prdata;
		logic       slverr;
	} adcc_state_t;

endpackage : adcc_pkg

/* hw/adcc_control.sv */
//------------------------------------------------------------
// Purpose: Converter control, result and pin logic behind APB
// Assumes: Analog core converts while convBusy, result on coreResult
// Notes:   No wait states, pready is high in the first access cycle
//------------------------------------------------------------
// What this block does
// - With auto trigger on, a rising edge of the chosen source starts a conversion
// - Done flag sets when a conversion ends and the result is loaded
// - Interrupt request is flag and enable and global enable together
// - Vector acknowledge clears the done flag
// - Writing one to the flag clears it, zero leaves it
// - Writing the flag back as one drops a pending request
// - Divide select picks system clock over 2,2,4,8,16,32,64,128
// - Result low byte at base index, high byte at base plus one
// - Reading the low byte freezes the result until the high byte is read
// - Differential results are kept as two's complement
// - Right aligned: result in bits 9..0, upper six read zero
// - Left aligned: result in bits 15..6, lower six read zero
// - Without auto trigger the source select has no effect
// - Source codes: free run, comparator, ext int 0, timer events
// - Trigger is a rising edge of the selected flag, also on reselect
// - Switching to free running never makes a trigger
// - Comparator negative input from mux when enabled bit set and converter off
// - Input disable bits force the pin value to zero
// - Conversions take 13 converter clocks, the first one 25
// - Clearing the enable bit aborts a running conversion
// - Start bit reads one while converting, writing zero does nothing
`timescale 1ns/1ns
`default_nettype none

module adcc_control
	import adcc_pkg::*;
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        reset,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Trigger source flags, index is the source code
	input  wire logic [7:1]  trigSources,
	// Processor interrupt side
	input  wire logic        globalIrqEnable,
	input  wire logic        irqVectorAck,
	output logic             convIrq,
	// Analog core
	input  wire logic [9:0]  coreResult,
	input  wire logic        diffSelected,
	output logic             convClkTick,
	output logic             convBusy,
	output logic             convFirst,
	output logic             compNegFromMux,
	// Analog pins, digital path
	input  wire logic [7:0]  pinRaw,
	output logic      [7:0]  pinValue,
	output logic      [7:0]  inputBufferOff
);

	//------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------
	// Divider terminal count per select code
	function automatic logic [6:0] divLast(input logic [2:0] code);
		logic [7:0] f;
		f = (code == 3'h0) ? 8'd2 : (8'd1 << code);
		return 7'(f - 8'd1);
	endfunction : divLast

	// Result view at the chosen alignment
	function automatic logic [15:0] alignView(input logic [9:0] r, input logic left);
		return left ? {r, 6'h00} : {6'h00, r};
	endfunction : alignView

	adcc_state_t s_r;
	adcc_state_t s_nxt;

	logic        accWr;
	logic        accRd;
	logic        setupRd;
	logic        lockNow;
	logic [7:0]  idx;
	logic [7:0]  wbyte;
	logic        mapped;
	logic        tick;
	logic        done;
	logic        trigSel;
	logic        trigEdge;
	logic        freeEdge;
	logic        swStart;
	logic        startNow;
	logic [15:0] view;
	logic [7:0]  rbyte;

	//------------------------------------------------------------
	// Bus decode
	//------------------------------------------------------------
	assign idx     = paddr[9:2];
	assign wbyte   = pwdata[7:0];
	assign accWr   = psel & penable & pwrite & mapped;
	assign accRd   = psel & penable & ~pwrite & mapped;
	assign setupRd = psel & ~penable;
	assign lockNow = setupRd & ~pwrite & mapped & (idx == IDX_RESULT_LO);
	assign mapped  = (paddr[11:10] == 2'b00) && (paddr[1:0] == 2'b00) &&
	                 (idx == IDX_RESULT_LO || idx == IDX_RESULT_HI || idx == IDX_CTRL_A ||
	                  idx == IDX_CTRL_B || idx == IDX_FORMAT || idx == IDX_DIDR);
	assign view    = alignView(s_r.result, s_r.lalign);

	// Read mux
	always_comb begin
		unique case (idx)
			IDX_RESULT_LO: rbyte = view[7:0];
			IDX_RESULT_HI: rbyte = view[15:8];
			IDX_CTRL_A:    rbyte = {s_r.en, s_r.start, s_r.ate, s_r.flag, s_r.ie, s_r.div};
			IDX_CTRL_B:    rbyte = {1'b0, s_r.comparator_mux_enable, 3'h0, s_r.tsel};
			IDX_FORMAT:    rbyte = {2'b00, s_r.lalign, 5'h00};
			IDX_DIDR:      rbyte = s_r.didr;
			default:       rbyte = RESET_BYTE;
		endcase
	end

	//------------------------------------------------------------
	// Prescaler, trigger and start decisions
	//------------------------------------------------------------
	assign tick = s_r.en && (s_r.preCnt >= divLast(s_r.div));
	assign done = s_r.start && tick && (s_r.convCnt + 5'd1 == s_r.convLen);

	// Selected source, forced low without auto trigger
	always_comb begin
		if (!s_r.ate || s_r.tsel == TSEL_FREE) begin
			trigSel = 1'b0;
		end else begin
			trigSel = trigSources[s_r.tsel];
		end
	end

	assign trigEdge = trigSel & ~s_r.trigPrev;
	assign freeEdge = s_r.ate && s_r.tsel == TSEL_FREE && s_r.flag && !s_r.flagPrev;
	assign swStart  = accWr && idx == IDX_CTRL_A && wbyte[A_START_BIT] && wbyte[A_EN_BIT];
	assign startNow = !s_r.start && (swStart || (s_r.en && (trigEdge || freeEdge)));

	//------------------------------------------------------------
	// Next state
	//------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		// Pin synchroniser, change accepted when stages two and three agree
		s_nxt.pin1 = pinRaw;
		s_nxt.pin2 = s_r.pin1;
		s_nxt.pin3 = s_r.pin2;
		if (s_r.pin2 == s_r.pin3) begin
			s_nxt.pinStable = s_r.pin3;
		end
		s_nxt.pinOut   = s_r.pinStable & ~s_r.didr;
		s_nxt.trigPrev = trigSel;
		s_nxt.flagPrev = s_r.flag;

		// Prescaler runs only while enabled
		if (!s_r.en || tick) begin
			s_nxt.preCnt = 7'h00;
		end else begin
			s_nxt.preCnt = s_r.preCnt + 7'd1;
		end

		// Conversion progress
		if (s_r.start && tick) begin
			s_nxt.convCnt = s_r.convCnt + 5'd1;
		end

		// Register writes
		if (accWr) begin
			unique case (idx)
				IDX_CTRL_A: begin
					if (wbyte[A_EN_BIT] && !s_r.en) begin
						s_nxt.firstPend = 1'b1;
					end
					s_nxt.en  = wbyte[A_EN_BIT];
					s_nxt.ate = wbyte[A_ATE_BIT];
					s_nxt.ie  = wbyte[A_IE_BIT];
					s_nxt.div = wbyte[2:0];
					if (wbyte[A_FLAG_BIT]) begin
						s_nxt.flag = 1'b0;
					end
				end
				IDX_CTRL_B: begin
					s_nxt.comparator_mux_enable = wbyte[B_COMPARATOR_MUX_ENABLE_BIT];
					s_nxt.tsel = wbyte[2:0];
				end
				IDX_FORMAT: s_nxt.lalign = wbyte[F_LALIGN_BIT];
				IDX_DIDR:   s_nxt.didr   = wbyte;
				default: ;
			endcase
		end

		// Vector acknowledge clears the flag
		if (irqVectorAck) begin
			s_nxt.flag = 1'b0;
		end

		// Start a conversion
		if (startNow) begin
			s_nxt.start     = 1'b1;
			s_nxt.convCnt   = 5'd0;
			s_nxt.convLen   = (s_r.firstPend || (swStart && !s_r.en)) ? CONV_FIRST : CONV_NORMAL;
			s_nxt.firstPend = 1'b0;
		end

		// Completion, lock holds the old result
		if (done) begin
			s_nxt.start = 1'b0;
			if (!s_r.locked && !lockNow) begin
				s_nxt.result = coreResult;
			end
			s_nxt.flag = 1'b1;
		end

		// Disable aborts the running conversion
		if (!s_nxt.en) begin
			s_nxt.start = 1'b0;
		end

		// Lock as the low byte is captured, release on high byte read
		if (lockNow) begin
			s_nxt.locked = 1'b1;
		end else if (accRd && idx == IDX_RESULT_HI) begin
			s_nxt.locked = 1'b0;
		end

		// Read data and error captured in the setup cycle
		if (setupRd) begin
			s_nxt.prdata = (pwrite || !mapped) ? RESET_BYTE : rbyte;
			s_nxt.slverr = !mapped;
		end
	end

	//------------------------------------------------------------
	// State register
	//------------------------------------------------------------
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	//------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------
	assign pready         = psel & penable;
	assign prdata         = {24'h00_0000, s_r.prdata};
	assign pslverr        = psel & penable & s_r.slverr;
	assign convIrq        = s_r.flag & s_r.ie & globalIrqEnable;
	assign convClkTick    = tick;
	assign convBusy       = s_r.start;
	assign convFirst      = s_r.start && s_r.convLen == CONV_FIRST;
	assign compNegFromMux = s_r.comparator_mux_enable & ~s_r.en;
	assign pinValue       = s_r.pinOut;
	assign inputBufferOff = s_r.didr;

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	sequence s_convEnds;
		done;
	endsequence

	property p_doneSetsFlag;
		@(posedge mclk) disable iff (reset) s_convEnds |=> s_r.flag && !s_r.start;
	endproperty
	a_doneSetsFlag: assert property (p_doneSetsFlag) else $error("flag not set at completion");

	property p_irqGate;
		@(posedge mclk) disable iff (reset) convIrq |-> s_r.flag && s_r.ie && globalIrqEnable;
	endproperty
	a_irqGate: assert property (p_irqGate) else $error("irq without all enables");

	property p_ackClears;
		@(posedge mclk) disable iff (reset) irqVectorAck && !done |=> !s_r.flag;
	endproperty
	a_ackClears: assert property (p_ackClears) else $error("ack left flag set");

	property p_writeZeroKeeps;
		@(posedge mclk) disable iff (reset)
			accWr && idx == IDX_CTRL_A && !wbyte[A_FLAG_BIT] && s_r.flag && !irqVectorAck |=> s_r.flag;
	endproperty
	a_writeZeroKeeps: assert property (p_writeZeroKeeps) else $error("zero write cleared flag");

	property p_lockHolds;
		@(posedge mclk) disable iff (reset) s_r.locked |=> $stable(s_r.result);
	endproperty
	a_lockHolds: assert property (p_lockHolds) else $error("locked result changed");

	property p_abort;
		@(posedge mclk) disable iff (reset) $fell(s_r.en) |-> !s_r.start;
	endproperty
	a_abort: assert property (p_abort) else $error("conversion survived disable");

	property p_noTrigWithoutAte;
		@(posedge mclk) disable iff (reset) !s_r.ate && !swStart && !s_r.start |=> !s_r.start;
	endproperty
	a_noTrigWithoutAte: assert property (p_noTrigWithoutAte) else $error("start without cause");

	sequence s_edgeSeen;
		s_r.en && s_r.ate && trigEdge && !s_r.start && s_nxt.en;
	endsequence

	property p_edgeStarts;
		@(posedge mclk) disable iff (reset) s_edgeSeen |=> s_r.start ##0 s_r.convCnt == 5'd0;
	endproperty
	a_edgeStarts: assert property (p_edgeStarts) else $error("edge did not start");

	property p_rightAlign;
		@(posedge mclk) disable iff (reset)
			setupRd && !pwrite && idx == IDX_RESULT_HI && !s_r.lalign |=> prdata[7:2] == 6'h00;
	endproperty
	a_rightAlign: assert property (p_rightAlign) else $error("upper bits not zero");

	property p_leftAlign;
		@(posedge mclk) disable iff (reset)
			setupRd && !pwrite && idx == IDX_RESULT_LO && s_r.lalign |=> prdata[5:0] == 6'h00;
	endproperty
	a_leftAlign: assert property (p_leftAlign) else $error("lower bits not zero");

	property p_flagOnlyOnDone;
		@(posedge mclk) disable iff (reset) $rose(s_r.flag) |-> $past(done);
	endproperty
	a_flagOnlyOnDone: assert property (p_flagOnlyOnDone) else $error("flag set without completion");

	property p_diffStored;
		@(posedge mclk) disable iff (reset)
			done && diffSelected && !s_r.locked && !lockNow |=> s_r.result == $past(coreResult);
	endproperty
	a_diffStored: assert property (p_diffStored) else $error("differential result altered");

	// Divide by two: next tick two cycles after the last
	sequence s_fastTick;
		tick && s_r.div <= 3'h1 ##1 s_r.en && s_r.div <= 3'h1;
	endsequence

	property p_fastTick;
		@(posedge mclk) disable iff (reset) s_fastTick |=> (s_r.en && s_r.div <= 3'h1 |-> tick);
	endproperty
	a_fastTick: assert property (p_fastTick) else $error("tick spacing wrong");

	property p_firstLength;
		@(posedge mclk) disable iff (reset)
			startNow && s_nxt.en |=> convBusy && convFirst == ($past(s_r.firstPend) || !$past(s_r.en));
	endproperty
	a_firstLength: assert property (p_firstLength) else $error("wrong conversion length");

	property p_freeRetrigger;
		@(posedge mclk) disable iff (reset)
			s_r.en && s_r.ate && s_r.tsel == TSEL_FREE && $rose(s_r.flag) && !s_r.start && s_nxt.en |=> convBusy;
	endproperty
	a_freeRetrigger: assert property (p_freeRetrigger) else $error("free running did not retrigger");

	property p_pinMask;
		@(posedge mclk) disable iff (reset) ##1 ($past(s_r.didr) & pinValue) == 8'h00;
	endproperty
	a_pinMask: assert property (p_pinMask) else $error("disabled pin read one");

	property p_lengthBound;
		@(posedge mclk) disable iff (reset) s_r.start |-> s_r.convCnt < s_r.convLen;
	endproperty
	a_lengthBound: assert property (p_lengthBound) else $error("conversion overran");

endmodule : adcc_control

`default_nettype wire

/* sim/adcc_core_model.sv */
//------------------------------------------------------------
// Purpose: Analog core stand-in for the converter control bench
// Assumes: Result sampled by the block while convBusy is high
// Notes:   Measures converter ticks per conversion and tick spacing
//------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none

module adcc_core_model (
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       reset,
	// Control from the block
	input  wire logic       convBusy,
	input  wire logic       convClkTick,
	input  wire logic [9:0] sampleVal,
	// Result and measurements
	output logic      [9:0] coreResult,
	output logic      [7:0] lastTicks,
	output logic      [7:0] lastGap
);
	logic [7:0] cnt;
	logic [7:0] cyc;

	// Result valid only while converting, inverted otherwise
	assign coreResult = convBusy ? sampleVal : ~sampleVal;

	// Tick count of each conversion and spacing between ticks
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			cnt       <= 8'h00;
			cyc       <= 8'h00;
			lastTicks <= 8'h00;
			lastGap   <= 8'h00;
		end else begin
			cyc <= convClkTick ? 8'h01 : cyc + 8'h01;
			if (convClkTick)
				lastGap <= cyc;
			if (convBusy)
				cnt <= cnt + {7'h00, convClkTick};
			else if (cnt != 8'h00) begin
				lastTicks <= cnt;
				cnt       <= 8'h00;
			end
		end
	end
endmodule : adcc_core_model

`default_nettype wire

/* sim/tb_top.sv */
//------------------------------------------------------------
// Purpose: Self-checking bench of the converter control
// Assumes: APB without wait states, core model on the far side
// Notes:   Expected values come from a small integer model
//------------------------------------------------------------
`timescale 1ns/1ns
`default_nettype none

module tb_top
	import adcc_pkg::*;
;
	localparam logic [7:0] REGS [6] = '{IDX_RESULT_LO, IDX_RESULT_HI, IDX_CTRL_A, IDX_CTRL_B, IDX_FORMAT, IDX_DIDR};
	logic        mclk, reset, psel, penable, pwrite, globalIrqEnable, irqVectorAck, diffSelected;
	logic        pready, pslverr, convIrq, convClkTick, convBusy, convFirst, compNegFromMux, errv;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [7:1]  trigSources;
	logic [7:0]  pinRaw, pinValue, inputBufferOff, rdv, dv, lastTicks, lastGap;
	logic [9:0]  coreResult, sampleVal;
	int          num_errors, comparisons, seed, expFlag, lalign, locked, i;
	int          expQ[$];

	adcc_control adcc_control_inst (.mclk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .trigSources, .globalIrqEnable, .irqVectorAck, .convIrq, .coreResult, .diffSelected,
		.convClkTick, .convBusy, .convFirst, .compNegFromMux, .pinRaw, .pinValue, .inputBufferOff);
	adcc_core_model adcc_core_model_inst (.mclk, .reset, .convBusy, .convClkTick, .sampleVal, .coreResult,
		.lastTicks, .lastGap);

	// Clock, 50 ns period
	always #25 mclk = ~mclk;

	// Comparison of bytes and counts
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t byte got %h exp %h", $time, got, exp);
		end
	endtask : chk8

	// Comparison of single flags
	task automatic chk1(input logic got, input logic exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %0t flag got %b exp %b", $time, got, exp);
		end
	endtask : chk1

	// One APB transfer, held until pready at a rising edge
	task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
		int n;
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= {2'b00, idx, 2'b00};
		pwdata  <= {24'h00_0000, wd};
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			num_errors++;
			$display("MISMATCH %0t no pready", $time);
		end
		rdv = prdata[7:0];
		errv = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
		apb(1'b1, idx, wd);
	endtask : wr

	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk8(rdv, exp);
	endtask : rd

	// Bounded wait for a busy level
	task automatic waitB(input logic lvl);
		int n;
		n = 0;
		while (convBusy !== lvl && n < 4000) begin
			@(posedge mclk);
			n++;
		end
		chk1(convBusy, lvl);
	endtask : waitB

	// Start by a control write, flag cleared by a written one
	task automatic strt(input logic [7:0] wd);
		sampleVal <= 10'($random(seed));
		wr(IDX_CTRL_A, wd);
		waitB(1'b1);
		if (wd[A_FLAG_BIT])
			expFlag = 0;
		chk1(convIrq, expFlag[0]);
	endtask : strt

	// Completion: flag, result update, length and tick spacing
	task automatic fin(input int len, input int gap);
		waitB(1'b0);
		repeat (2) @(posedge mclk);
		expFlag = 1;
		if (locked == 0)
			expQ.push_back(int'(sampleVal));
		chk1(convIrq, 1'b1);
		chk8(lastTicks, 8'(len));
		chk8(lastGap, 8'(gap));
	endtask : fin

	// Result bytes in the chosen alignment, low read locks
	task automatic rres(input int part);
		logic [15:0] v;
		v = lalign != 0 ? 16'(expQ[$]) << 6 : 16'(expQ[$]);
		if (part[0]) begin
			rd(IDX_RESULT_LO, v[7:0]);
			locked = 1;
		end
		if (part[1]) begin
			rd(IDX_RESULT_HI, v[15:8]);
			locked = 0;
		end
	endtask : rres

	// Verdict and end of run
	task automatic results();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	// Watchdog
	initial begin
		repeat (60000) @(posedge mclk);
		num_errors++;
		results();
	end

	// Main sequence
	initial begin
		{mclk, psel, penable, pwrite, irqVectorAck, diffSelected, globalIrqEnable} = '0;
		{paddr, pwdata, trigSources, pinRaw, sampleVal} = '0;
		{num_errors, comparisons, expFlag, lalign, locked} = '0;
		seed = 36833;
		reset = 1'b1;
		repeat (20) @(posedge mclk);
		reset <= 1'b0;
		globalIrqEnable <= 1'b1;
		for (i = 0; i < 6; i++)
			rd(REGS[i], RESET_BYTE);
		apb(1'b0, 8'h7D, 8'h00);
		chk1(errv, 1'b1);
		chk8(rdv, 8'h00);
		// Input disable masks the synchronised pins
		dv = 8'($random(seed));
		pinRaw <= 8'($random(seed));
		wr(IDX_DIDR, dv);
		rd(IDX_DIDR, dv);
		for (i = 0; i < 20 && pinValue !== (pinRaw & ~dv); i++)
			@(posedge mclk);
		chk8(pinValue, pinRaw & ~dv);
		chk8(inputBufferOff, dv);
		// Comparator input hand-over
		wr(IDX_CTRL_B, 8'h40);
		@(posedge mclk);
		chk1(compNegFromMux, 1'b1);
		wr(IDX_CTRL_A, 8'h88);
		@(posedge mclk);
		chk1(compNegFromMux, 1'b0);
		// First conversion, start bit behaviour, interrupt gating
		strt(8'hC8);
		chk1(convFirst, 1'b1);
		rd(IDX_CTRL_A, 8'hC8);
		wr(IDX_CTRL_A, 8'h88);
		@(posedge mclk);
		chk1(convBusy, 1'b1);
		fin(25, 2);
		globalIrqEnable <= 1'b0;
		@(posedge mclk);
		chk1(convIrq, 1'b0);
		globalIrqEnable <= 1'b1;
		irqVectorAck <= 1'b1;
		@(posedge mclk);
		irqVectorAck <= 1'b0;
		expFlag = 0;
		@(posedge mclk);
		chk1(convIrq, 1'b0);
		rres(3);
		// Every divide code, even codes right aligned, odd codes left aligned
		for (i = 0; i < 8; i++) begin
			lalign = i % 2;
			wr(IDX_FORMAT, lalign != 0 ? 8'h20 : 8'h00);
			diffSelected <= 1'($random(seed));
			strt(8'hD8 | 8'(i));
			fin(13, i < 2 ? 2 : 1 << i);
			rres(3);
		end
		// Locked result survives a completion
		rres(1);
		strt(8'hD8);
		fin(13, 2);
		rres(2);
		rres(3);
		// Abort by clearing enable, then a new first conversion
		strt(8'hD8);
		wr(IDX_CTRL_A, 8'h08);
		repeat (2) @(posedge mclk);
		chk1(convBusy, 1'b0);
		repeat (60) @(posedge mclk);
		chk1(convIrq, 1'b0);
		strt(8'hC8);
		fin(25, 2);
		// Each trigger source by a one-cycle pulse
		for (i = 1; i < 8; i++) begin
			wr(IDX_CTRL_B, 8'(i));
			wr(IDX_CTRL_A, 8'hB8);
			expFlag = 0;
			trigSources[i] <= 1'b1;
			@(posedge mclk);
			trigSources[i] <= 1'b0;
			waitB(1'b1);
			fin(13, 2);
		end
		wr(IDX_CTRL_A, 8'h98);
		expFlag = 0;
		trigSources[7] <= 1'b1;
		@(posedge mclk);
		trigSources[7] <= 1'b0;
		repeat (10) @(posedge mclk);
		chk1(convBusy, 1'b0);
		// Reselect onto a set source
		wr(IDX_CTRL_B, 8'h01);
		wr(IDX_CTRL_A, 8'hB8);
		trigSources[2] <= 1'b1;
		wr(IDX_CTRL_B, 8'h02);
		waitB(1'b1);
		fin(13, 2);
		trigSources[2] <= 1'b0;
		wr(IDX_CTRL_B, 8'h00);
		repeat (10) @(posedge mclk);
		chk1(convBusy, 1'b0);
		// Free running retrigger from its own flag
		strt(8'hF8);
		fin(13, 2);
		waitB(1'b1);
		wr(IDX_CTRL_A, 8'h98);
		expFlag = 0;
		fin(13, 2);
		rres(3);
		results();
	end
endmodule : tb_top

`default_nettype wire
